// >>> core/port_ctrl_defines.svh
// register offsets, reset values and bit positions of the port control block
`ifndef PORT_CTRL_DEFINES_SVH
`define PORT_CTRL_DEFINES_SVH
`define ADDR_PORT_ZERO_PINS 8'h80
`define ADDR_PORT_ONE_PINS 8'h90
`define ADDR_SHARED_EXTERNAL_FLAGS 8'h91
`define ADDR_PORT_ONE_FALL_STATUS 8'h93
`define ADDR_PORT_ZERO_DIRECTION 8'h94
`define ADDR_PORT_ONE_DIRECTION 8'h95
`define ADDR_PORT_TWO_DIRECTION 8'h96
`define ADDR_PORT_THREE_DIRECTION 8'h97
`define ADDR_PORT_ONE_IRQ_ENABLE 8'h9b
`define ADDR_PORT_ONE_PULLUP 8'h9d
`define ADDR_PORT_TWO_PULLUP 8'h9e
`define ADDR_PORT_THREE_PULLUP 8'h9f
`define ADDR_PORT_TWO_PINS 8'ha0
`define ADDR_PORT_FOUR_PULLUP 8'ha2
`define ADDR_PORT_THREE_PINS 8'hb0
`define RESET_DIRECTION 8'hff
`define RESET_PINS 8'hff
`define RESET_ZERO 8'h00
`define BIT_GROUP_TWO_EXT_FLAG 0
`define BIT_GROUP_THREE_EXT_FLAG 1
`define BIT_CALLER_ID_IRQ_FLAG 2
`define BIT_DIVIDER_OVERFLOW_FLAG 3
`define BIT_COMPARATOR_RISE_FLAG 4
`define FLAGS_IMPL_MASK 8'h1f
`endif

// >>> core/port_ctrl_pkg.sv
// types shared by the port control block
package port_ctrl_pkg;
    typedef logic [7:0] byte_type;
    typedef logic [3:0] nibble_type;
endpackage

// >>> core/pin_sync_if.sv
// carrier between a pin synchroniser and its user
`timescale 1ns/1ns
interface pin_sync_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] fall;
    modport source (output level, output fall);
    modport sink (input level, input fall);
endinterface

// >>> core/pin_sync.sv
// two-flop pin synchroniser with falling-edge pulse
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] pins_in,
    pin_sync_if.source sync
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] last;
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync width must be positive");
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta <= '1;
            stable <= '1;
            last <= '1;
        end else if (ce_in) begin
            meta <= pins_in;
            stable <= meta;
            last <= stable;
        end
    end
    assign sync.level = stable;
    // one pulse per fall
    assign sync.fall = last & ~stable & {WIDTH{ce_in}};
endmodule

// >>> core/rise_detect.sv
// rising-edge detector on a same-clock level
`timescale 1ns/1ns
module rise_detect (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic level_in,
    output logic rise_out
);
    logic last;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            last <= 1'b0;
        end else if (ce_in) begin
            last <= level_in;
        end
    end
    assign rise_out = ce_in & level_in & ~last;
endmodule

// >>> core/port_ctrl.sv
// port direction, pull-high and port one falling-edge interrupt registers
`timescale 1ns/1ns
`include "port_ctrl_defines.svh"
module port_ctrl (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic [7:0] port_zero_pins_in,
    output logic [7:0] port_zero_pins_out,
    output logic [7:0] port_zero_pins_oe_out,
    input wire logic [7:0] port_one_pins_in,
    output logic [7:0] port_one_pins_out,
    output logic [7:0] port_one_pins_oe_out,
    input wire logic [7:0] port_two_pins_in,
    output logic [7:0] port_two_pins_out,
    output logic [7:0] port_two_pins_oe_out,
    input wire logic [7:0] port_three_pins_in,
    output logic [7:0] port_three_pins_out,
    output logic [7:0] port_three_pins_oe_out,
    output logic [7:0] port_one_pullup_out,
    output logic [7:0] port_two_pullup_out,
    output logic [7:0] port_three_pullup_out,
    output logic [7:0] port_four_pullup_out,
    input wire logic caller_id_any_flag_in,
    input wire logic comparator_result_in,
    input wire logic divider_overflow_in,
    output logic ext_irq_group_two_out,
    output logic ext_irq_group_three_out
);
    port_ctrl_pkg::byte_type port_zero_latch;
    port_ctrl_pkg::byte_type port_one_latch;
    port_ctrl_pkg::byte_type port_two_latch;
    port_ctrl_pkg::byte_type port_three_latch;
    port_ctrl_pkg::byte_type port_zero_direction;
    port_ctrl_pkg::byte_type port_one_direction;
    port_ctrl_pkg::byte_type port_two_direction;
    port_ctrl_pkg::byte_type port_three_direction;
    port_ctrl_pkg::byte_type port_one_irq_enable;
    port_ctrl_pkg::byte_type port_one_fall_status;
    port_ctrl_pkg::byte_type port_one_pullup;
    port_ctrl_pkg::byte_type port_two_pullup;
    port_ctrl_pkg::byte_type port_three_pullup;
    port_ctrl_pkg::byte_type port_four_pullup;
    port_ctrl_pkg::byte_type shared_external_flags;
    port_ctrl_pkg::byte_type pin_fall;
    port_ctrl_pkg::byte_type next_rdata;
    port_ctrl_pkg::nibble_type group_two_hits;
    port_ctrl_pkg::nibble_type group_three_hits;
    logic group_two_event;
    logic group_three_event;
    logic comparator_rise;
    logic caller_id_sync_meta;
    logic caller_id_sync;
    logic comparator_meta;
    logic comparator_sync;
    logic divider_meta;
    logic divider_sync;
    logic wr;

    pin_sync_if #(.WIDTH(8)) zero_sync();
    pin_sync_if #(.WIDTH(8)) one_sync();
    pin_sync_if #(.WIDTH(8)) two_sync();
    pin_sync_if #(.WIDTH(8)) three_sync();

    // all port inputs synchronised
    pin_sync #(.WIDTH(8)) u_sync_zero (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .pins_in(port_zero_pins_in), .sync(zero_sync.source)
    );
    pin_sync #(.WIDTH(8)) u_sync_one (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .pins_in(port_one_pins_in), .sync(one_sync.source)
    );
    pin_sync #(.WIDTH(8)) u_sync_two (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .pins_in(port_two_pins_in), .sync(two_sync.source)
    );
    pin_sync #(.WIDTH(8)) u_sync_three (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .pins_in(port_three_pins_in), .sync(three_sync.source)
    );

    // side inputs from other blocks, treated as asynchronous
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            caller_id_sync_meta <= 1'b0;
            caller_id_sync <= 1'b0;
            comparator_meta <= 1'b0;
            comparator_sync <= 1'b0;
            divider_meta <= 1'b0;
            divider_sync <= 1'b0;
        end else if (ce_in) begin
            caller_id_sync_meta <= caller_id_any_flag_in;
            caller_id_sync <= caller_id_sync_meta;
            comparator_meta <= comparator_result_in;
            comparator_sync <= comparator_meta;
            divider_meta <= divider_overflow_in;
            divider_sync <= divider_meta;
        end
    end

    rise_detect u_comp_rise (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .level_in(comparator_sync), .rise_out(comparator_rise)
    );

    assign wr = sfr_wr_in & ce_in;

    // pin_fall keeps every fall; group events take enabled input-mode falls only
    assign pin_fall = one_sync.fall;
    assign group_two_hits = pin_fall[3:0] & port_one_irq_enable[3:0]
        & port_one_direction[3:0];
    assign group_three_hits = pin_fall[7:4] & port_one_irq_enable[7:4]
        & port_one_direction[7:4];
    assign group_two_event = |group_two_hits;
    assign group_three_event = |group_three_hits;

    // output latches of the pins
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            port_zero_latch <= `RESET_PINS;
            port_one_latch <= `RESET_PINS;
            port_two_latch <= `RESET_PINS;
            port_three_latch <= `RESET_PINS;
        end else if (wr) begin
            if (sfr_addr_in == `ADDR_PORT_ZERO_PINS) port_zero_latch <= sfr_wdata_in;
            if (sfr_addr_in == `ADDR_PORT_ONE_PINS) port_one_latch <= sfr_wdata_in;
            if (sfr_addr_in == `ADDR_PORT_TWO_PINS) port_two_latch <= sfr_wdata_in;
            if (sfr_addr_in == `ADDR_PORT_THREE_PINS) port_three_latch <= sfr_wdata_in;
        end
    end

    // direction registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            port_zero_direction <= `RESET_DIRECTION;
            port_one_direction <= `RESET_DIRECTION;
            port_two_direction <= `RESET_DIRECTION;
            port_three_direction <= `RESET_DIRECTION;
        end else if (wr) begin
            if (sfr_addr_in == `ADDR_PORT_ZERO_DIRECTION) port_zero_direction <= sfr_wdata_in;
            if (sfr_addr_in == `ADDR_PORT_ONE_DIRECTION) port_one_direction <= sfr_wdata_in;
            if (sfr_addr_in == `ADDR_PORT_TWO_DIRECTION) port_two_direction <= sfr_wdata_in;
            if (sfr_addr_in == `ADDR_PORT_THREE_DIRECTION) begin
                port_three_direction <= sfr_wdata_in;
            end
        end
    end

    // interrupt enable
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            port_one_irq_enable <= `RESET_ZERO;
        end else if (wr && sfr_addr_in == `ADDR_PORT_ONE_IRQ_ENABLE) begin
            port_one_irq_enable <= sfr_wdata_in;
        end
    end

    // pull-high enables
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            port_one_pullup <= `RESET_ZERO;
            port_two_pullup <= `RESET_ZERO;
            port_three_pullup <= `RESET_ZERO;
            port_four_pullup <= `RESET_ZERO;
        end else if (wr) begin
            if (sfr_addr_in == `ADDR_PORT_ONE_PULLUP) port_one_pullup <= sfr_wdata_in;
            if (sfr_addr_in == `ADDR_PORT_TWO_PULLUP) port_two_pullup <= sfr_wdata_in;
            if (sfr_addr_in == `ADDR_PORT_THREE_PULLUP) port_three_pullup <= sfr_wdata_in;
            if (sfr_addr_in == `ADDR_PORT_FOUR_PULLUP) port_four_pullup <= sfr_wdata_in;
        end
    end

    // sticky fall status; a write of zero clears, a new fall wins
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            port_one_fall_status <= `RESET_ZERO;
        end else if (ce_in) begin
            if (wr && sfr_addr_in == `ADDR_PORT_ONE_FALL_STATUS) begin
                port_one_fall_status <= (port_one_fall_status & sfr_wdata_in) | pin_fall;
            end else begin
                port_one_fall_status <= port_one_fall_status | pin_fall;
            end
        end
    end

    // shared flags, hardware set wins over software clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            shared_external_flags <= `RESET_ZERO;
        end else if (ce_in) begin
            if (wr && sfr_addr_in == `ADDR_SHARED_EXTERNAL_FLAGS) begin
                shared_external_flags <= sfr_wdata_in & `FLAGS_IMPL_MASK;
            end
            if (group_two_event) begin
                shared_external_flags[`BIT_GROUP_TWO_EXT_FLAG] <= 1'b1;
            end
            if (group_three_event) begin
                shared_external_flags[`BIT_GROUP_THREE_EXT_FLAG] <= 1'b1;
            end
            if (caller_id_sync) begin
                shared_external_flags[`BIT_CALLER_ID_IRQ_FLAG] <= 1'b1;
            end
            if (divider_sync) begin
                shared_external_flags[`BIT_DIVIDER_OVERFLOW_FLAG] <= 1'b1;
            end
            if (comparator_rise) begin
                shared_external_flags[`BIT_COMPARATOR_RISE_FLAG] <= 1'b1;
            end
        end
    end

    // group interrupt pulses toward the interrupt controller
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ext_irq_group_two_out <= 1'b0;
            ext_irq_group_three_out <= 1'b0;
        end else if (ce_in) begin
            ext_irq_group_two_out <= group_two_event;
            ext_irq_group_three_out <= group_three_event;
        end
    end

    // pin drivers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            port_zero_pins_out <= `RESET_ZERO;
            port_zero_pins_oe_out <= `RESET_ZERO;
            port_one_pins_out <= `RESET_PINS;
            port_one_pins_oe_out <= `RESET_ZERO;
            port_two_pins_out <= `RESET_PINS;
            port_two_pins_oe_out <= `RESET_ZERO;
            port_three_pins_out <= `RESET_PINS;
            port_three_pins_oe_out <= `RESET_ZERO;
        end else if (ce_in) begin
            port_zero_pins_out <= `RESET_ZERO;
            port_zero_pins_oe_out <= ~port_zero_direction & ~port_zero_latch;
            port_one_pins_out <= port_one_latch;
            port_one_pins_oe_out <= ~port_one_direction;
            port_two_pins_out <= port_two_latch;
            port_two_pins_oe_out <= ~port_two_direction;
            port_three_pins_out <= port_three_latch;
            port_three_pins_oe_out <= ~port_three_direction;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            port_one_pullup_out <= `RESET_ZERO;
            port_two_pullup_out <= `RESET_ZERO;
            port_three_pullup_out <= `RESET_ZERO;
            port_four_pullup_out <= `RESET_ZERO;
        end else if (ce_in) begin
            port_one_pullup_out <= port_one_pullup;
            port_two_pullup_out <= port_two_pullup;
            port_three_pullup_out <= port_three_pullup;
            port_four_pullup_out <= port_four_pullup;
        end
    end

    // read mux: pin ports return synchronised pin level
    always_comb begin
        unique case (sfr_addr_in)
            `ADDR_PORT_ZERO_PINS: next_rdata = zero_sync.level;
            `ADDR_PORT_ONE_PINS: next_rdata = one_sync.level;
            `ADDR_PORT_TWO_PINS: next_rdata = two_sync.level;
            `ADDR_PORT_THREE_PINS: next_rdata = three_sync.level;
            `ADDR_SHARED_EXTERNAL_FLAGS: next_rdata = shared_external_flags;
            `ADDR_PORT_ONE_FALL_STATUS: next_rdata = port_one_fall_status;
            `ADDR_PORT_ZERO_DIRECTION: next_rdata = port_zero_direction;
            `ADDR_PORT_ONE_DIRECTION: next_rdata = port_one_direction;
            `ADDR_PORT_TWO_DIRECTION: next_rdata = port_two_direction;
            `ADDR_PORT_THREE_DIRECTION: next_rdata = port_three_direction;
            `ADDR_PORT_ONE_IRQ_ENABLE: next_rdata = port_one_irq_enable;
            `ADDR_PORT_ONE_PULLUP: next_rdata = port_one_pullup;
            `ADDR_PORT_TWO_PULLUP: next_rdata = port_two_pullup;
            `ADDR_PORT_THREE_PULLUP: next_rdata = port_three_pullup;
            `ADDR_PORT_FOUR_PULLUP: next_rdata = port_four_pullup;
            default: next_rdata = `RESET_ZERO;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sfr_rdata_out <= `RESET_ZERO;
        end else if (ce_in) begin
            sfr_rdata_out <= next_rdata;
        end
    end
endmodule

// >>> dv/port_ctrl_properties.sv
// assertions on the port control block ports
`timescale 1ns/1ns
module port_ctrl_properties (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic [7:0] port_zero_pins_out,
    input wire logic [7:0] port_one_pins_in,
    input wire logic [7:0] port_one_pins_oe_out,
    input wire logic [7:0] port_one_pullup_out,
    input wire logic [7:0] port_four_pullup_out,
    input wire logic ext_irq_group_two_out,
    input wire logic ext_irq_group_three_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence wr_at(logic [7:0] a);
        ce_in && sfr_wr_in && sfr_addr_in == a;
    endsequence
    a_dir_reset: assert property (disable iff (1'b0)
        !rst_n_in |=> port_one_pins_oe_out == 8'h00) else $error("port one not input");
    a_pull_reset: assert property (disable iff (1'b0)
        !rst_n_in |=> (port_one_pullup_out | port_four_pullup_out) == 8'h00)
        else $error("pull-high not off after reset");
    a_oe_follows_dir: assert property (
        wr_at(8'h95) ##1 (ce_in && !(sfr_wr_in && sfr_addr_in == 8'h95))
        |=> port_one_pins_oe_out == ~$past(sfr_wdata_in, 2)) else $error("drive enable wrong");
    a_dir_readback: assert property (
        wr_at(8'h95) ##1 (ce_in && !sfr_wr_in && sfr_addr_in == 8'h95)
        |=> sfr_rdata_out == $past(sfr_wdata_in, 2)) else $error("direction readback wrong");
    a_pull_four: assert property (
        wr_at(8'ha2) ##1 (ce_in && !(sfr_wr_in && sfr_addr_in == 8'ha2))
        |=> port_four_pullup_out == $past(sfr_wdata_in, 2)) else $error("port four pull wrong");
    a_flags_unused: assert property (ce_in && sfr_addr_in == 8'h91 |=>
        sfr_rdata_out[7:5] == 3'h0) else $error("flag bits 7 to 5 not zero");
    a_zero_open_drain: assert property (port_zero_pins_out == 8'h00)
        else $error("port zero drives high");
    a_two_after_fall: assert property (ext_irq_group_two_out |->
        |($past(port_one_pins_in[3:0], 4) & ~$past(port_one_pins_in[3:0], 3)))
        else $error("group two pulse without fall");
    a_three_after_fall: assert property (ext_irq_group_three_out |->
        |($past(port_one_pins_in[7:4], 4) & ~$past(port_one_pins_in[7:4], 3)))
        else $error("group three pulse without fall");
    a_two_single: assert property (
        ext_irq_group_two_out |=> !ext_irq_group_two_out)
        else $error("group two pulse too long");
    a_three_single: assert property (
        ext_irq_group_three_out |=> !ext_irq_group_three_out)
        else $error("group three pulse too long");
    c_two: cover property (ext_irq_group_two_out);
    c_three: cover property (ext_irq_group_three_out);
    c_dir_write: cover property (wr_at(8'h95));
endmodule
bind port_ctrl port_ctrl_properties u_port_ctrl_properties (.clk_in, .rst_n_in, .ce_in,
    .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out, .port_zero_pins_out,
    .port_one_pins_in, .port_one_pins_oe_out, .port_one_pullup_out, .port_four_pullup_out,
    .ext_irq_group_two_out, .ext_irq_group_three_out);

// >>> dv/pin_board.sv
// board-side pin model: external drivers, pull-highs, floating pins
`timescale 1ns/1ns
module pin_board #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input wire logic clk_in,
    input wire logic [7:0] out_in,
    input wire logic [7:0] oe_in,
    input wire logic [7:0] pullup_in,
    input wire logic [7:0] ext_in,
    input wire logic [7:0] ext_en_in,
    output logic [7:0] level_out
);
    logic flip = 1'b0;
    always_ff @(posedge clk_in) begin
        flip <= ~flip;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (oe_in[i]) begin
                level_out[i] = OPEN_DRAIN ? 1'b0 : out_in[i];
            end else if (ext_en_in[i]) begin
                level_out[i] = ext_in[i];
            end else begin
                level_out[i] = pullup_in[i] | flip;
            end
        end
    end
endmodule

// >>> dv/port_direction_pullup_irq_test.sv
// self-checking bench for the port control block
`timescale 1ns/1ns
module port_direction_pullup_irq_test;
    typedef struct {logic [7:0] a; logic [7:0] r; logic [7:0] d; logic [7:0] e;} row_type;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sfr_wr_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [7:0] ext_one = 8'hff;
    logic [7:0] ext_side = 8'h00;
    logic [7:0] ext_side_en = 8'h00;
    logic ce_in = 1'b1;
    logic [2:0] side_ev = 3'h0;
    logic [7:0] rdata, lvl0, lvl1, lvl2, lvl3, o0, o1, o2, o3, e0, e1, e2, e3, h1, h2, h3, h4;
    logic irq2, irq3;
    int n_fail = 0;
    int checks_done = 0;
    int n_two = 0;
    int n_three = 0;
    logic [7:0] ev_set [3] = '{8'h04, 8'h10, 8'h08};
    logic [7:0] ev_held [3] = '{8'h04, 8'h00, 8'h08};
    row_type rows [12] = '{'{8'h94, 8'hff, 8'h3c, 8'h3c}, '{8'h95, 8'hff, 8'h5a, 8'h5a},
        '{8'h96, 8'hff, 8'hc3, 8'hc3}, '{8'h97, 8'hff, 8'h0f, 8'h0f},
        '{8'h9b, 8'h00, 8'ha5, 8'ha5}, '{8'h9d, 8'h00, 8'h81, 8'h81},
        '{8'h9e, 8'h00, 8'h7e, 8'h7e}, '{8'h9f, 8'h00, 8'h18, 8'h18},
        '{8'ha2, 8'h00, 8'he7, 8'he7}, '{8'h93, 8'h00, 8'hff, 8'h00},
        '{8'h91, 8'h00, 8'hff, 8'h1f}, '{8'h92, 8'h00, 8'h55, 8'h00}};
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    port_ctrl u_port_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_rdata_out(rdata), .port_zero_pins_in(lvl0), .port_zero_pins_out(o0),
        .port_zero_pins_oe_out(e0), .port_one_pins_in(lvl1), .port_one_pins_out(o1),
        .port_one_pins_oe_out(e1), .port_two_pins_in(lvl2), .port_two_pins_out(o2),
        .port_two_pins_oe_out(e2), .port_three_pins_in(lvl3), .port_three_pins_out(o3),
        .port_three_pins_oe_out(e3), .port_one_pullup_out(h1), .port_two_pullup_out(h2),
        .port_three_pullup_out(h3), .port_four_pullup_out(h4),
        .caller_id_any_flag_in(side_ev[0]), .comparator_result_in(side_ev[1]),
        .divider_overflow_in(side_ev[2]), .ext_irq_group_two_out(irq2),
        .ext_irq_group_three_out(irq3));
    pin_board #(.OPEN_DRAIN(1'b1)) board_zero (.clk_in(clk_in), .out_in(o0), .oe_in(e0),
        .pullup_in(8'h00), .ext_in(ext_side), .ext_en_in(ext_side_en), .level_out(lvl0));
    pin_board board_one (.clk_in(clk_in), .out_in(o1), .oe_in(e1), .pullup_in(h1),
        .ext_in(ext_one), .ext_en_in(8'hff), .level_out(lvl1));
    pin_board board_two (.clk_in(clk_in), .out_in(o2), .oe_in(e2), .pullup_in(h2),
        .ext_in(ext_side), .ext_en_in(ext_side_en), .level_out(lvl2));
    pin_board board_three (.clk_in(clk_in), .out_in(o3), .oe_in(e3), .pullup_in(h3),
        .ext_in(ext_side), .ext_en_in(ext_side_en), .level_out(lvl3));
    always @(negedge clk_in) begin
        n_two += (irq2 === 1'b1);
        n_three += (irq3 === 1'b1);
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(negedge clk_in);
        sfr_wr_in = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        sfr_addr_in = a;
        @(negedge clk_in);
        check(rdata, exp);
    endtask
    task automatic fall(input logic [7:0] m);
        @(negedge clk_in);
        ext_one = ~m;
        repeat (10) @(negedge clk_in);
        ext_one = 8'hff;
        repeat (6) @(negedge clk_in);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (8) @(negedge clk_in);
        rst_n_in = 1'b1;
        foreach (rows[i]) begin
            rdc(rows[i].a, rows[i].r);
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        check(e1, 8'ha5);
        check(e2, 8'h3c);
        check(e3, 8'hf0);
        check(h1, 8'h81);
        check(h2, 8'h7e);
        check(h3, 8'h18);
        check(h4, 8'he7);
        wr(8'h80, 8'h00);
        wr(8'ha0, 8'h5a);
        wr(8'hb0, 8'ha5);
        @(negedge clk_in);
        check(e0, 8'hc3);
        check(lvl0 & 8'hc3 | o0, 8'h00);
        check(o2, 8'h5a);
        check(o3, 8'ha5);
        ce_in = 1'b0;
        wr(8'h9d, 8'h55);
        ce_in = 1'b1;
        rdc(8'h9d, 8'h81);
        check(h1, 8'h81);
        $display("test registers done");
        wr(8'h95, 8'hff);
        wr(8'h9b, 8'h0f);
        wr(8'h93, 8'h00);
        wr(8'h91, 8'h00);
        fall(8'h02);
        check(8'(n_two), 8'h01);
        fall(8'h20);
        check(8'(n_three), 8'h00);
        rdc(8'h93, 8'h22);
        rdc(8'h91, 8'h01);
        wr(8'h9b, 8'hff);
        fall(8'h80);
        check(8'(n_three), 8'h01);
        wr(8'h95, 8'hbf);
        wr(8'h90, 8'hbf);
        repeat (10) @(negedge clk_in);
        check(8'(n_three), 8'h01);
        check(o1, 8'hbf);
        rdc(8'h93, 8'he2);
        rdc(8'h91, 8'h03);
        wr(8'h93, 8'hfd);
        rdc(8'h93, 8'he0);
        wr(8'h91, 8'h00);
        $display("test port one interrupts done");
        for (int k = 0; k < 3; k++) begin
            @(negedge clk_in);
            side_ev = 3'(1 << k);
            repeat (6) @(negedge clk_in);
            rdc(8'h91, ev_set[k]);
            wr(8'h91, 8'h00);
            repeat (6) @(negedge clk_in);
            rdc(8'h91, ev_held[k]);
            side_ev = 3'h0;
            repeat (6) @(negedge clk_in);
            wr(8'h91, 8'h00);
        end
        $display("test shared flags done");
        @(negedge clk_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        rdc(8'h95, 8'hff);
        rdc(8'h9b, 8'h00);
        rdc(8'h93, 8'h00);
        rdc(8'h91, 8'h00);
        check(h1 | h4, 8'h00);
        ext_side = 8'h96;
        ext_side_en = 8'hff;
        repeat (3) @(negedge clk_in);
        rdc(8'h80, 8'h96);
        rdc(8'ha0, 8'h96);
        rdc(8'hb0, 8'h96);
        $display("test second reset done");
        conclude();
    end
endmodule
